// ===== testbench.sv
// Purpose: Self-checking bench of the tributary pointer generator
// Assumes: Registers over classic Wishbone, slots from the feed model
// Notes:   Random payload traffic from a fixed-seed shift register
`timescale 1ns/100ps
module testbench;
  import tpg_pkg::*;
  // Flag sets: {spill, in_ndf, pi_alarm, interpreter_lost_pointer, interpreter_in_normal}
  localparam logic [4:0] F_N   = 5'h01;
  localparam logic [4:0] F_LOP = 5'h02;
  localparam logic [4:0] F_AIS = 5'h04;
  localparam logic [4:0] F_NDF = 5'h09;
  localparam logic [4:0] F_SPL = 5'h11;
  localparam logic [8:0] SKIP  = 9'h100;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  tpg_slot_t   slot_i;
  tpg_slot_t   cmd = '0;
  logic        slot_valid;
  logic        cmd_go = 1'b0;
  logic        taken;
  logic [1:0]  mf_in = 2'h0;
  logic [1:0]  phase_o;
  logic [7:0]  out_byte;
  logic        out_valid;
  logic        out_v5_mark;
  logic        out_spe_mark;
  logic        fifo_pop;
  logic [4:0]  pop_trib;
  logic        offset_discontinuity;
  int          num_errors = 0;
  int          total_checks = 0;
  logic [15:0] lfsr = 16'h0032;  // Fixed seed
  logic [31:0] rd;               // Last read data
  logic [7:0]  g_data = 8'h00;   // Payload byte of the next slot
  logic        g_tag = 1'b0;     // Tag of the next slot
  logic [9:0]  g_pos = 10'h000;  // Position of the next slot
  logic [4:0]  t;
  always #2 clk = ~clk;
  tpg_core DUT (.clk(clk), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .slot_i(slot_i), .slot_valid(slot_valid), .outgoing_multiframe_input(mf_in), .phase_o(phase_o),
    .out_byte(out_byte), .out_valid(out_valid), .out_v5_mark(out_v5_mark), .out_spe_mark(out_spe_mark),
    .fifo_pop(fifo_pop), .pop_trib(pop_trib), .offset_discontinuity(offset_discontinuity));
  tpg_feed u_feed (.clk(clk), .reset_n(reset_n), .phase_o(phase_o), .cmd(cmd), .cmd_go(cmd_go),
    .taken(taken), .slot_i(slot_i), .slot_valid(slot_valid));
  // Next shift register value
  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsr_next
  // First pointer byte: flag, size bits, offset top
  function automatic logic [7:0] ptr_hi(input logic [3:0] ndf, input logic [1:0] ss, input logic [9:0] off);
    return {ndf, ss, off[9:8]};
  endfunction : ptr_hi
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : give_verdict
  // Classic single cycle; request held until ack is sampled
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int n;
    n = 0;
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'hf;
    wb_dat_i <= dat;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20) num_errors++;
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask : wb
  // One slot: hand it to the feed, wait for the answer, compare the byte
  task automatic sl(input tpg_kind_t k, input logic [4:0] tr, input logic [4:0] f, input logic [4:0] fl,
                    input logic [8:0] exp);
    int n;
    n = 0;
    cmd    <= '{kind: k, trib: tr, pos: g_pos, data: g_data, tag: g_tag, fill: f, spill: fl[4],
                 in_ndf: fl[3], pi_alarm: fl[2], interpreter_lost_pointer: fl[1], interpreter_in_normal: fl[0], mf: 2'h0};
    cmd_go <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (taken !== 1'b1 && n < 12);
    cmd_go <= 1'b0;
    do begin
      @(posedge clk);
      n++;
    end while (out_valid !== 1'b1 && n < 24);
    if (n >= 24) num_errors++;
    if (!exp[8]) chk(out_byte, exp);
  endtask : sl
  // One pointer frame: V1 then V2
  task automatic fr(input logic [4:0] tr, input logic [4:0] f, input logic [4:0] fl,
                    input logic [7:0] v1, input logic [7:0] v2);
    sl(K_V1, tr, f, fl, {1'b0, v1});
    sl(K_V2, tr, f, fl, {1'b0, v2});
  endtask : fr
  // Watchdog far beyond the few hundred cycles the run needs
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    give_verdict();
  end
  initial begin
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    // Reset values, unmapped place, field widths
    for (int j = 0; j < 5; j++) begin
      wb(1'b0, 8'(j * 4 + (j == 4 ? 4 : 0)), 32'h0);
      chk(rd, 32'h0);
    end
    wb(1'b1, TPG_REG_CTRL, 32'hffffffff);
    wb(1'b0, TPG_REG_CTRL, 32'h0);
    chk(rd, 32'h0000003f);
    wb(1'b1, TPG_REG_AIS, 32'hffffffff);
    wb(1'b0, TPG_REG_AIS, 32'h0);
    chk(rd, 32'h0fffffff);
    wb(1'b1, TPG_REG_CTRL, 32'h0);
    wb(1'b1, TPG_REG_AIS, 32'h0);
    $display("test registers done");
    // Multiframe byte for every phase
    for (logic [2:0] m = 0; m < 4; m++) begin
      mf_in <= m[1:0];
      sl(K_H4, 5'h00, FIFO_MID, F_N, {1'b0, H4_TOP, m[1:0]});
    end
    $display("test multiframe done");
    // Quiet frames, then wide band holds at fill 6, narrow band justifies
    repeat (4) begin
      fr(5'h01, FIFO_MID, F_N, 8'h60, 8'h00);
      fr(5'h02, FIFO_MID, F_N, 8'h60, 8'h00);
    end
    fr(5'h01, 5'h06, F_N, 8'h60, 8'h00);
    wb(1'b1, TPG_REG_CTRL, 32'h1);
    fr(5'h01, 5'h06, F_N, ptr_hi(NDF_OFF, 2'h0, I_MASK), I_MASK[7:0]);
    sl(K_V3, 5'h01, 5'h06, F_N, {1'b0, STUFF_BY});
    chk(fifo_pop, 1'b0);
    sl(K_V3N, 5'h01, 5'h06, F_N, {1'b0, STUFF_BY});
    chk(fifo_pop, 1'b0);
    fr(5'h01, 5'h06, F_N, 8'h60, 8'h01);
    wb(1'b0, TPG_REG_STAT, 32'h0);
    chk(rd, {12'h000, 5'h01, ST_NORM, 10'h001});
    wb(1'b1, TPG_REG_CTRL, 32'h0);
    fr(5'h02, 5'h10, F_N, ptr_hi(NDF_OFF, 2'h0, D_MASK), D_MASK[7:0]);
    g_data = 8'hc3;
    sl(K_V3, 5'h02, FIFO_MID, F_N, 9'h0c3);
    chk(fifo_pop, 1'b1);
    sl(K_V3N, 5'h02, FIFO_MID, F_N, SKIP);
    fr(5'h02, FIFO_MID, F_N, 8'h63, 8'hff);
    $display("test justification done");
    // Tagged byte with incoming new data flag
    g_pos = 10'h05a;
    g_tag = 1'b1;
    g_data = 8'h5e;
    sl(K_PAY, 5'h03, FIFO_MID, F_NDF, 9'h05e);
    chk({out_v5_mark, out_spe_mark, fifo_pop, pop_trib}, {3'b111, 5'h03});
    chk(offset_discontinuity, 1'b1);
    g_tag = 1'b0;
    fr(5'h03, FIFO_MID, F_N, ptr_hi(NDF_ON, 2'h0, 10'h05a), 8'h5a);
    sl(K_V3N, 5'h03, FIFO_MID, F_N, SKIP);
    fr(5'h03, FIFO_MID, F_N, 8'h60, 8'h5a);
    wb(1'b1, TPG_REG_INV, 32'h8);
    fr(5'h03, FIFO_MID, F_N, 8'h90, 8'h5a);
    wb(1'b1, TPG_REG_INV, 32'h0);
    sl(K_PAY, 5'h09, FIFO_MID, F_SPL, {1'b0, g_data});
    chk(offset_discontinuity, 1'b1);
    $display("test new data flag done");
    // Alarm entry and exit, lost pointer with and without the option
    fr(5'h04, FIFO_MID, F_AIS, 8'hff, 8'hff);
    sl(K_PAY, 5'h04, FIFO_MID, F_AIS, 9'h0ff);
    fr(5'h04, FIFO_MID, F_N, 8'h90, 8'h00);
    fr(5'h05, FIFO_MID, F_LOP, 8'hff, 8'hff);
    wb(1'b1, TPG_REG_CTRL, 32'h22);
    fr(5'h0a, FIFO_MID, F_LOP, 8'h68, 8'h00);
    wb(1'b1, TPG_REG_AIS, 32'h40);
    sl(K_PAY, 5'h06, FIFO_MID, F_N, 9'h0ff);
    wb(1'b1, TPG_REG_AIS, 32'h0);
    wb(1'b1, TPG_REG_IDLE, 32'h80);
    wb(1'b1, TPG_REG_CTRL, 32'h0);
    sl(K_PAY, 5'h07, FIFO_MID, F_N, 9'h000);
    wb(1'b1, TPG_REG_CTRL, 32'h4);
    sl(K_PAY, 5'h07, FIFO_MID, F_N, 9'h0ff);
    sl(K_V1, 5'h07, FIFO_MID, F_N, 9'h060);
    wb(1'b1, TPG_REG_IDLE, 32'h0);
    wb(1'b1, TPG_REG_CTRL, 32'h0);
    $display("test alarm and insertion done");
    // Random payload across many tributaries
    repeat (40) begin
      lfsr = lfsr_next(lfsr);
      t = 5'h0b + {1'b0, lfsr[3:0]};
      g_data = lfsr[15:8];
      g_pos = lfsr[9:0];
      sl(K_PAY, t, FIFO_MID, F_N, {1'b0, g_data});
      chk({fifo_pop, pop_trib}, {1'b1, t});
    end
    $display("test random payload done");
    give_verdict();
  end
endmodule : testbench

// ===== tpg_core.sv
// Purpose: Time-sliced outgoing tributary pointer generator
// Assumes: Slot inputs held by the timing generator in phase 0
// Notes:   One slot takes three clocks: fetch, compute, write back
`timescale 1ns/100ps
module tpg_core
  import tpg_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Slot inputs
  input  wire tpg_slot_t   slot_i,
  input  wire logic        slot_valid,
  input  wire logic [1:0]  outgoing_multiframe_input,
  // Slot outputs
  output logic      [1:0]  phase_o,
  output logic      [7:0]  out_byte,
  output logic             out_valid,
  output logic             out_v5_mark,
  output logic             out_spe_mark,
  output logic             fifo_pop,
  output logic      [4:0]  pop_trib,
  output logic             offset_discontinuity
);
  // Registers
  logic [5:0]       ctrl_q;   // Band, lop option, idle, ss
  logic [27:0]      ais_q;    // Forced AIS mask
  logic [27:0]      idle_q;   // Forced idle mask
  logic [27:0]      inv_q;    // Forced inverted flag mask
  logic [19:0]      stat_q;   // Last trib, state, offset
  logic             ack_q;
  logic [31:0]      rdat_q;
  // Slot pipeline
  logic [1:0]       ph_q;
  logic             busy_q;   // Slot fetched in phase 0
  tpg_slot_t        slot_q;
  tpg_rec_t         work_q;
  tpg_rec_t         nxt;
  tpg_rec_t         ram [NTRIB];  // State vector store
  tpg_kind_t        okind_q;  // Kind of last emitted byte
  logic [4:0]       ost_q;    // State used for last byte
  // Combinational slot results
  logic             alarm, frame, ok_age, lo_ev, hi_ev;
  logic [4:0]       band, lo_thr, hi_thr;
  logic [15:0]      ptr;
  logic [3:0]       ndf;
  logic [7:0]       byte_d, pay_byte;
  logic             pop_d, spe_d, ais_out;
  logic             bus_req;
  // Write merge honouring byte selects
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) r[8*i +: 8] = nw[8*i +: 8];
    end
    return r;
  endfunction : merge

  assign bus_req = wb_cyc_i && wb_stb_i && !ack_q;
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
  assign phase_o = ph_q;

  // Bus answer one cycle after the request, dropped the next cycle
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ack_q  <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else begin
      ack_q  <= bus_req;
      rdat_q <= 32'h0000_0000;
      if (bus_req && !wb_we_i) begin
        unique case (wb_adr_i)
          TPG_REG_CTRL: rdat_q <= {26'h0, ctrl_q};
          TPG_REG_AIS:  rdat_q <= {4'h0, ais_q};
          TPG_REG_IDLE: rdat_q <= {4'h0, idle_q};
          TPG_REG_INV:  rdat_q <= {4'h0, inv_q};
          TPG_REG_STAT: rdat_q <= {12'h0, stat_q};
          default:      rdat_q <= 32'h0000_0000;  // Unmapped reads zero
        endcase
      end
    end
  end

  // Register writes take effect with the ack edge
  // Merged word is cut to the field width on purpose
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ctrl_q <= CTRL_RESET;
      ais_q  <= 28'h0;
      idle_q <= 28'h0;
      inv_q  <= 28'h0;
    end else if (bus_req && wb_we_i) begin
      unique case (wb_adr_i)
        TPG_REG_CTRL: ctrl_q <= 6'(merge({26'h0, ctrl_q}, wb_dat_i, wb_sel_i));
        TPG_REG_AIS:  ais_q  <= 28'(merge({4'h0, ais_q}, wb_dat_i, wb_sel_i));
        TPG_REG_IDLE: idle_q <= 28'(merge({4'h0, idle_q}, wb_dat_i, wb_sel_i));
        TPG_REG_INV:  inv_q  <= 28'(merge({4'h0, inv_q}, wb_dat_i, wb_sel_i));
        default: ;  // Writes elsewhere ignored
      endcase
    end
  end

  // Phase counter splits each slot into fetch, compute, write back
  always_ff @(posedge clk) begin
    if (!reset_n) ph_q <= 2'h0;
    else if (ph_q == PH_LAST) ph_q <= 2'h0;
    else ph_q <= ph_q + 2'h1;
  end

  // Thresholds sit symmetric about the midpoint of the FIFO
  assign band   = ctrl_q[CTRL_NARROW] ? BAND_NARR : BAND_WIDE;
  assign lo_thr = FIFO_MID - band;
  assign hi_thr = FIFO_MID + band;
  // Lost pointer may be kept from forcing the alarm state
  assign alarm  = slot_q.pi_alarm || (slot_q.interpreter_lost_pointer && !ctrl_q[CTRL_NOLOP]);
  assign frame  = slot_q.kind == K_V1;
  assign ok_age = work_q.age > AGE_MIN;
  assign lo_ev  = (slot_q.fill < lo_thr) && ok_age;
  assign hi_ev  = (slot_q.fill > hi_thr) && ok_age;

  // Next state vector of the tributary in hand
  always_comb begin
    nxt = work_q;
    // Discontinuity: a new event wins over the clear
    if (slot_q.in_ndf || slot_q.spill) nxt.disc = 1'b1;
    if (frame && work_q.age < AGE_MAX) nxt.age = work_q.age + 3'h1;
    if (frame) begin
      unique case (work_q.st)
        ST_NORM: begin
          if (alarm) nxt.st = ST_AIS;
          else if (work_q.disc) begin
            // Incoming NDF and buffer spill events, taken once per frame
            nxt.st = ST_NDF;
            nxt.off = work_q.tag_pos;
            nxt.disc = slot_q.in_ndf || slot_q.spill;
          end else if (hi_ev) nxt.st = ST_DEC;
          else if (lo_ev) nxt.st = ST_INC;
        end
        ST_AIS: begin
          // Leave alarm only once the interpreter is normal again
          if (!alarm && slot_q.interpreter_in_normal) begin
            nxt.st = ST_NDF;
            nxt.off = work_q.tag_pos;
            nxt.disc = slot_q.in_ndf || slot_q.spill;
          end
        end
        ST_NDF, ST_INC, ST_DEC: begin
          if (alarm) nxt.st = ST_AIS;
        end
      endcase
    end
    // Action states close after the byte after H3
    if (slot_q.kind == K_V3N) begin
      unique case (work_q.st)
        ST_INC: begin
          nxt.off = work_q.off + 10'h001;
          nxt.st = ST_NORM;
          nxt.age = 3'h0;
        end
        ST_DEC: begin
          nxt.off = work_q.off - 10'h001;
          nxt.st = ST_NORM;
          nxt.age = 3'h0;
        end
        ST_NDF: begin
          nxt.st = ST_NORM;
          nxt.age = 3'h0;
        end
        default: ;
      endcase
    end
    // Tag position sets where the next pointer will point
    if (pop_d && slot_q.tag) nxt.tag_pos = slot_q.pos;
  end

  // Pointer word and byte selection for the slot
  always_comb begin
    ndf = (nxt.st == ST_NDF) ? NDF_ON : NDF_OFF;
    if (inv_q[slot_q.trib]) ndf = ~ndf;
    ptr = {ndf, ctrl_q[CTRL_SS_LO +: 2], nxt.off};
    if (nxt.st == ST_INC) ptr[9:0] = nxt.off ^ I_MASK;
    if (nxt.st == ST_DEC) ptr[9:0] = nxt.off ^ D_MASK;
    // Interpreter AIS, forced AIS and the alarm state all fill ones
    ais_out = (nxt.st == ST_AIS) || ais_q[slot_q.trib] || slot_q.pi_alarm;
    pay_byte = slot_q.data;
    if (idle_q[slot_q.trib]) pay_byte = ctrl_q[CTRL_IDLE1] ? 8'hff : 8'h00;
    pop_d = 1'b0;
    spe_d = 1'b0;
    byte_d = 8'h00;
    unique case (slot_q.kind)
      K_H4: byte_d = {H4_TOP, slot_q.mf};
      K_V1: byte_d = ptr[15:8];
      K_V2: byte_d = ptr[7:0];
      K_V3: begin
        // Negative justification carries data in H3
        pop_d = (work_q.st == ST_DEC);
        spe_d = pop_d;
        byte_d = pop_d ? pay_byte : STUFF_BY;
      end
      K_V3N: begin
        // Positive justification stuffs this byte
        pop_d = (work_q.st != ST_INC);
        spe_d = pop_d;
        byte_d = pop_d ? pay_byte : STUFF_BY;
      end
      K_PAY: begin
        pop_d = 1'b1;
        spe_d = 1'b1;
        byte_d = pay_byte;
      end
      default: ;
    endcase
    if (ais_out && slot_q.kind != K_H4 && slot_q.kind != K_NONE) byte_d = 8'hff;
  end

  // Slot fetch, compute and write back
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      busy_q <= 1'b0;
      slot_q <= '0;
      // Legal record so the state stays one-hot from the first edge
      work_q <= '{st: ST_NORM, off: 10'h000, tag_pos: 10'h000, age: 3'h0, disc: 1'b0};
      for (int i = 0; i < NTRIB; i++) begin
        ram[i] <= '{st: ST_NORM, off: 10'h000, tag_pos: 10'h000, age: 3'h0, disc: 1'b0};
      end
    end else begin
      unique case (ph_q)
        2'h0: begin
          busy_q <= slot_valid && slot_i.trib < NTRIB;
          slot_q <= slot_i;
          slot_q.mf <= outgoing_multiframe_input;
          // Withdrawn slots may carry any index; never read past the store
          if (slot_i.trib < NTRIB) work_q <= ram[slot_i.trib];
        end
        2'h1: if (busy_q) work_q <= nxt;
        default: if (busy_q) ram[slot_q.trib] <= work_q;
      endcase
    end
  end

  // Registered outputs, updated at the end of the compute phase
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      out_byte <= 8'h00;
      out_valid <= 1'b0;
      out_v5_mark <= 1'b0;
      out_spe_mark <= 1'b0;
      fifo_pop <= 1'b0;
      pop_trib <= 5'h00;
      offset_discontinuity <= 1'b0;
      okind_q <= K_NONE;
      ost_q <= ST_NORM;
      stat_q <= 20'h00000;
    end else begin
      out_valid <= (ph_q == 2'h1) && busy_q;
      fifo_pop <= (ph_q == 2'h1) && busy_q && pop_d;
      offset_discontinuity <= (ph_q == 2'h1) && busy_q && (slot_q.in_ndf || slot_q.spill);
      if (ph_q == 2'h1 && busy_q) begin
        out_byte <= byte_d;
        out_v5_mark <= pop_d && slot_q.tag;
        out_spe_mark <= spe_d;
        pop_trib <= slot_q.trib;
        okind_q <= slot_q.kind;
        ost_q <= nxt.st;
        stat_q <= {slot_q.trib, nxt.st, nxt.off};
      end
    end
  end

  // Checks
  property p_h4;
    @(posedge clk) disable iff (!reset_n)
      out_valid && okind_q == K_H4 |-> out_byte[7:2] == H4_TOP;
  endproperty
  a_h4: assert property (p_h4) else $error("H4 top bits not ones");
  property p_onehot;
    @(posedge clk) disable iff (!reset_n) $onehot(work_q.st);
  endproperty
  a_onehot: assert property (p_onehot) else $error("State not one-hot");
  property p_inc;
    @(posedge clk) disable iff (!reset_n)
      ph_q == 2'h1 && busy_q && slot_q.kind == K_V3N && work_q.st == ST_INC
      |=> work_q.st == ST_NORM && work_q.off == $past(work_q.off) + 10'h001 ##0 !fifo_pop;
  endproperty
  a_inc: assert property (p_inc) else $error("Increment not completed");
  property p_dec;
    @(posedge clk) disable iff (!reset_n)
      ph_q == 2'h1 && busy_q && slot_q.kind == K_V3N && work_q.st == ST_DEC
      |=> work_q.st == ST_NORM && work_q.off == $past(work_q.off) - 10'h001;
  endproperty
  a_dec: assert property (p_dec) else $error("Decrement not completed");
  property p_dec_h3;
    @(posedge clk) disable iff (!reset_n)
      ph_q == 2'h1 && busy_q && slot_q.kind == K_V3 && work_q.st == ST_DEC |=> fifo_pop && out_spe_mark;
  endproperty
  a_dec_h3: assert property (p_dec_h3) else $error("H3 carried no data");
  property p_ais;
    @(posedge clk) disable iff (!reset_n)
      out_valid && okind_q != K_H4 && okind_q != K_NONE && ost_q == ST_AIS |-> out_byte == 8'hff;
  endproperty
  a_ais: assert property (p_ais) else $error("Alarm byte not all ones");
  property p_ndf;
    @(posedge clk) disable iff (!reset_n)
      out_valid && okind_q == K_V1 && out_byte != 8'hff
      |-> out_byte[7:4] == NDF_ON || out_byte[7:4] == NDF_OFF;
  endproperty
  a_ndf: assert property (p_ndf) else $error("Bad flag code");
  property p_age;
    @(posedge clk) disable iff (!reset_n)
      ph_q == 2'h1 && busy_q && work_q.st == ST_NORM && frame && !alarm && !work_q.disc
      && work_q.age <= AGE_MIN |=> work_q.st == ST_NORM;
  endproperty
  a_age: assert property (p_age) else $error("Justified too soon");
  property p_ack;
    @(posedge clk) disable iff (!reset_n) bus_req |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("Bus ack not single cycle");
  c_inc: cover property (@(posedge clk) disable iff (!reset_n) work_q.st == ST_INC);
  c_dec: cover property (@(posedge clk) disable iff (!reset_n) work_q.st == ST_DEC);
  c_ndf: cover property (@(posedge clk) disable iff (!reset_n) work_q.st == ST_NDF);
  c_ais: cover property (@(posedge clk) disable iff (!reset_n) work_q.st == ST_AIS);
endmodule : tpg_core

// ===== tpg_feed.sv
// Purpose: Far-side model feeding slots from the timing generator and payload buffer
// Assumes: Engine reads a slot only while phase_o is 0
// Notes:   Slot fields are inverted once withdrawn, so stale values never look valid
`timescale 1ns/100ps
module tpg_feed
  import tpg_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  // Engine phase
  input  wire logic [1:0] phase_o,
  // Bench command
  input  wire tpg_slot_t  cmd,
  input  wire logic       cmd_go,
  output logic            taken,
  // Slot towards the engine
  output tpg_slot_t       slot_i,
  output logic            slot_valid
);
  // One slot per three clocks, shown only for the phase 0 cycle
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      slot_valid <= 1'b0;
      taken      <= 1'b0;
      slot_i     <= '0;
    end else begin
      taken <= (phase_o == 2'h0) && slot_valid;
      if (phase_o == PH_LAST && cmd_go) begin
        slot_i     <= cmd;
        slot_valid <= 1'b1;
      end else if (phase_o == 2'h0) begin
        // Withdrawn: scramble fields rather than hold them
        slot_i     <= ~slot_i;
        slot_valid <= 1'b0;
      end
    end
  end
endmodule : tpg_feed

// ===== tpg_pkg.sv
// Purpose: Shared constants and types of the tributary pointer generator
// Assumes: Classic Wishbone register access, 32-bit data
// Notes:   Offsets are byte addresses of aligned words
package tpg_pkg;
  // Register byte offsets
  localparam logic [7:0] TPG_REG_CTRL = 8'h00;
  localparam logic [7:0] TPG_REG_AIS  = 8'h04;
  localparam logic [7:0] TPG_REG_IDLE = 8'h08;
  localparam logic [7:0] TPG_REG_INV  = 8'h0c;
  localparam logic [7:0] TPG_REG_STAT = 8'h10;
  // Control field positions
  localparam int CTRL_NARROW = 0;
  localparam int CTRL_NOLOP  = 1;
  localparam int CTRL_IDLE1  = 2;
  localparam int CTRL_SS_LO  = 4;
  localparam logic [5:0] CTRL_RESET = 6'h00;
  // Tributary count and RAM depth
  localparam int NTRIB = 28;
  // Fill figures of the 16-byte FIFO
  localparam logic [4:0] FIFO_MID  = 5'h08;
  localparam logic [4:0] BAND_WIDE = 5'h02;
  localparam logic [4:0] BAND_NARR = 5'h01;
  // Frames that must pass after a pointer action
  localparam logic [2:0] AGE_MIN = 3'h3;
  localparam logic [2:0] AGE_MAX = 3'h4;
  // Pointer coding
  localparam logic [3:0] NDF_ON   = 4'h9;
  localparam logic [3:0] NDF_OFF  = 4'h6;
  localparam logic [9:0] I_MASK   = 10'h2aa;
  localparam logic [9:0] D_MASK   = 10'h155;
  localparam logic [5:0] H4_TOP   = 6'h3f;
  localparam logic [7:0] STUFF_BY = 8'h00;
  // Last phase of the three-cycle processing period
  localparam logic [1:0] PH_LAST = 2'h2;
  // Generator states, one-hot
  typedef enum logic [4:0] {
    ST_NORM = 5'b00001,
    ST_AIS  = 5'b00010,
    ST_NDF  = 5'b00100,
    ST_INC  = 5'b01000,
    ST_DEC  = 5'b10000
  } tpg_state_t;
  // Byte kinds named by the outgoing timing generator
  typedef enum logic [2:0] {
    K_NONE = 3'h0, K_H4 = 3'h1, K_V1 = 3'h2, K_V2 = 3'h3,
    K_V3 = 3'h4, K_V3N = 3'h5, K_PAY = 3'h6
  } tpg_kind_t;
  // Saved state vector of one tributary
  typedef struct packed {
    tpg_state_t  st;       // Generator state
    logic [9:0]  off;      // Active offset
    logic [9:0]  tag_pos;  // Position of last tagged byte
    logic [2:0]  age;      // Frames since last pointer action
    logic        disc;     // Pending offset discontinuity
  } tpg_rec_t;
  // One slot as presented by timing generator and neighbours
  typedef struct packed {
    tpg_kind_t   kind;
    logic [4:0]  trib;
    logic [9:0]  pos;      // Payload byte position in envelope
    logic [7:0]  data;     // FIFO head byte
    logic        tag;      // FIFO head carries the V5/J1 mark
    logic [4:0]  fill;     // FIFO fill level
    logic        spill;    // FIFO overflow or underflow
    logic        in_ndf;   // Enabled NDF seen on incoming side
    logic        pi_alarm; // Interpreter in AIS
    logic        interpreter_lost_pointer;   // Interpreter lost pointer
    logic        interpreter_in_normal;  // Interpreter in normal
    logic [1:0]  mf;       // Multiframe phase for H4
  } tpg_slot_t;
endpackage : tpg_pkg
